// ===== rtl/ufi_uart.sv
// ufi_uart: one serial channel with 16-deep fifos, interrupt ident
// and polled status. assumes resetn and the register port are on clk;
// serial and modem inputs are asynchronous pins.
// Overview of operation
// - trigger level raises data-available, drops below
// - line status outranks data available
// - data ready set on push, cleared empty
// - timeout after four idle character times
// - character times counted in baud ticks
// - single read clears timeout, restarts timer
// - new character or read restarts timer
// - empty fifo raises transmit event, cleared
// - single-byte empty indication delayed one char less a bit
// - fifo enable change gives immediate transmit event
// - timeout shares data priority, empty shares transmit
// - cleared enables give independent polled operation
// - line status bits in polled mode
// - polled mode hides trigger and timeout
// - high speed divisors 32770 and 32769
// - reset clears controls, status 60H, ident 01H
// - modem deltas cleared, levels follow pins
// - line errors set status and interrupt
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ufi_uart import ufi_pkg::*; (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStb,
   input  wire logic       rdStb,
   output logic      [7:0] rdData,
   input  wire logic       highSpeed,
   input  wire logic       serialIn,
   input  wire logic       ctsN,
   input  wire logic       dsrN,
   input  wire logic       riN,
   input  wire logic       dcdN,
   output logic            serialOutA,
   output logic            requestSendN,
   output logic            terminalReadyN,
   output logic            userOutputOneN,
   output logic            userOutputTwoN,
   output logic            intr
);

   ////////////////////////////////////////////////////////////////////
   logic [3:0]  ierQ;
   logic [7:0]  lcrQ, scrQ, rdDataQ, rdMux;
   logic [4:0]  mcrQ, pinMetaQ, pinSyncQ, pinOutQ;
   logic [15:0] divQ, divCntQ, divMax;
   logic [7:0]  preCntQ, preMax;
   logic        fifoEnQ, intrQ;
   logic [1:0]  trigQ;
   logic        dlab, loopMode, pen, eps, hsMode, preTick, baudTick;
   logic        dataWr, dataRd, ierWr, divWr, fcrWr, lsrRd, msrRd, iirRd;
   logic        enChange, rxClear, txClear;
   logic [3:0]  dataBits, charBits, nb, iirId;
   logic [7:0]  dataMask, charTicks, lsrVal;
   logic [4:0]  trigLevel, fifoCap;

   assign dlab     = lcrQ[LCR_DLAB];
   assign loopMode = mcrQ[MCR_LOOP];
   assign pen      = lcrQ[LCR_PEN];
   assign eps      = lcrQ[LCR_EPS];
   assign dataWr   = wrStb && addr == ADDR_DATA && !dlab;
   assign dataRd   = rdStb && addr == ADDR_DATA && !dlab;
   assign ierWr    = wrStb && addr == ADDR_IER && !dlab;
   assign divWr    = wrStb && (addr == ADDR_DATA || addr == ADDR_IER) && dlab;
   assign fcrWr    = wrStb && addr == ADDR_IIR;
   assign iirRd    = rdStb && addr == ADDR_IIR;
   assign lsrRd    = rdStb && addr == ADDR_LSR;
   assign msrRd    = rdStb && addr == ADDR_MSR;
   assign enChange = fcrWr && wrData[0] != fifoEnQ;
   // any change of the enable bit empties both fifos
   assign rxClear  = fcrWr && ((wrData[0] && wrData[1]) || enChange);
   assign txClear  = fcrWr && ((wrData[0] && wrData[2]) || enChange);
   assign fifoCap  = fifoEnQ ? FIFO_DEPTH : 5'h01;

   assign dataBits  = 4'h5 + {2'b00, lcrQ[1:0]};
   assign nb        = dataBits + {3'b000, pen};
   // a second stop bit is part of the character time
   assign charBits  = nb + (lcrQ[LCR_STB] ? 4'h3 : 4'h2);
   assign charTicks = {charBits, 4'h0};
   assign dataMask  = 8'hFF >> (4'h8 - dataBits);

   always_comb begin
      unique case (trigQ)
         2'b00: trigLevel = TRIG_L0;
         2'b01: trigLevel = TRIG_L1;
         2'b10: trigLevel = TRIG_L2;
         2'b11: trigLevel = TRIG_L3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // control registers, all cleared by reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ierQ    <= 4'h0;
         lcrQ    <= 8'h00;
         mcrQ    <= 5'h00;
         scrQ    <= 8'h00;
         divQ    <= 16'h0000;
         fifoEnQ <= 1'b0;
         trigQ   <= 2'b00;
      end else if (wrStb) begin
         if (ierWr) ierQ <= wrData[3:0];
         if (addr == ADDR_LCR) lcrQ <= wrData;
         if (addr == ADDR_MCR) mcrQ <= wrData[4:0];
         if (addr == ADDR_SCR) scrQ <= wrData;
         if (divWr && addr == ADDR_DATA) divQ[7:0] <= wrData;
         if (divWr && addr == ADDR_IER) divQ[15:8] <= wrData;
         if (fcrWr) begin
            fifoEnQ <= wrData[0];
            trigQ   <= wrData[7:6];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // baud generator; high speed with bit 15 picks x2 or x4
   assign hsMode  = highSpeed && divQ[15];
   assign preMax  = !hsMode ? PRE_NORM :
                    (divQ[1:0] == 2'b10 ? PRE_HS2 : PRE_HS4);
   assign divMax  = hsMode ? 16'h0001 :
                    (divQ == 16'h0000 ? 16'h0003 : divQ);
   assign preTick  = preCntQ == preMax - 8'h01;
   // every character time derives from this tick
   assign baudTick = preTick && divCntQ >= divMax - 16'h0001;

   always_ff @(posedge clk) begin
      if (!resetn || divWr) begin
         preCntQ <= 8'h00;
         divCntQ <= 16'h0000;
      end else begin
         preCntQ <= preTick ? 8'h00 : preCntQ + 8'h01;
         if (preTick) divCntQ <= baudTick ? 16'h0000 : divCntQ + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: serial in and the four modem inputs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pinMetaQ <= PIN_RESET;
         pinSyncQ <= PIN_RESET;
      end else begin
         pinMetaQ <= {dcdN, riN, dsrN, ctsN, serialIn};
         pinSyncQ <= pinMetaQ;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fifo storage, one generate loop over the entries
   logic [10:0] rxMemQ [16];
   logic [7:0]  txMemQ [16];
   logic [3:0]  rxWrPtrQ, rxRdPtrQ, txWrPtrQ, txRdPtrQ;
   logic [4:0]  rxCntQ, txCntQ, rxErrCntQ;
   logic        rxPush, rxPop, rxDone, rxFull, txPush, txPop;
   logic [10:0] rxEntry;

   for (genvar gi = 0; gi < 16; gi++) begin : gEntry
      always_ff @(posedge clk) begin
         if (!resetn || rxClear) begin
            rxMemQ[gi] <= 11'h000;
         end else if (rxPush && rxWrPtrQ == 4'(gi)) begin
            rxMemQ[gi] <= rxEntry;
         end
      end
      always_ff @(posedge clk) begin
         if (!resetn || txClear) begin
            txMemQ[gi] <= 8'h00;
         end else if (txPush && txWrPtrQ == 4'(gi)) begin
            txMemQ[gi] <= wrData;
         end
      end
   end

   // fifos keep buffering whether or not interrupts are enabled
   assign rxFull = rxCntQ >= fifoCap;
   assign rxPush = rxDone && !rxFull;
   assign rxPop  = dataRd && rxCntQ != 5'h00;
   assign txPush = dataWr && txCntQ < fifoCap;

   always_ff @(posedge clk) begin
      if (!resetn || rxClear) begin
         rxWrPtrQ  <= 4'h0;
         rxRdPtrQ  <= 4'h0;
         rxCntQ    <= 5'h00;
         rxErrCntQ <= 5'h00;
      end else begin
         if (rxPush) rxWrPtrQ <= rxWrPtrQ + 4'h1;
         if (rxPop) rxRdPtrQ <= rxRdPtrQ + 4'h1;
         rxCntQ <= rxCntQ + {4'h0, rxPush} - {4'h0, rxPop};
         rxErrCntQ <= rxErrCntQ + {4'h0, rxPush && |rxEntry[10:8]}
                      - {4'h0, rxPop && |rxMemQ[rxRdPtrQ][10:8]};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || txClear) begin
         txWrPtrQ <= 4'h0;
         txRdPtrQ <= 4'h0;
         txCntQ   <= 5'h00;
      end else begin
         if (txPush) txWrPtrQ <= txWrPtrQ + 4'h1;
         if (txPop) txRdPtrQ <= txRdPtrQ + 4'h1;
         txCntQ <= txCntQ + {4'h0, txPush} - {4'h0, txPop};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receiver, 16x oversampled, sampled mid-bit
   ufi_rx_state_t rxStateQ;
   logic [3:0]    rxTickQ, rxBitQ;
   logic [8:0]    rxShQ, rxAligned;
   logic [7:0]    rxData;
   logic          rxLine, rxPar, rxPe, rxBreak, txBit;

   assign rxLine    = loopMode ? txBit : pinSyncQ[0];
   assign rxAligned = rxShQ >> (4'h9 - nb);
   assign rxData    = rxAligned[7:0] & dataMask;
   assign rxPar     = pen && rxAligned[dataBits];
   assign rxPe      = pen && (lcrQ[LCR_STICK] ? rxPar == eps
                                              : (^{rxData, rxPar}) == eps);
   assign rxBreak   = !rxLine && rxData == 8'h00 && !rxPar;
   assign rxDone    = rxStateQ == RX_STOP && baudTick && rxTickQ == RX_LAST;
   // a break loads a single zero character
   assign rxEntry   = {rxBreak, !rxLine, rxPe, rxData};

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rxStateQ <= RX_IDLE;
         rxTickQ  <= 4'h0;
         rxBitQ   <= 4'h0;
         rxShQ    <= 9'h000;
      end else begin
         unique case (rxStateQ)
            RX_IDLE: begin
               rxTickQ <= 4'h0;
               if (!rxLine) rxStateQ <= RX_START;
            end
            RX_START: if (baudTick) begin
               rxTickQ <= rxTickQ + 4'h1;
               if (rxTickQ == RX_MID) begin
                  rxTickQ  <= 4'h0;
                  rxBitQ   <= 4'h0;
                  rxStateQ <= rxLine ? RX_IDLE : RX_BITS;
               end
            end
            RX_BITS: if (baudTick) begin
               rxTickQ <= rxTickQ + 4'h1;
               if (rxTickQ == RX_LAST) begin
                  rxShQ  <= {rxLine, rxShQ[8:1]};
                  rxBitQ <= rxBitQ + 4'h1;
                  if (rxBitQ == nb - 4'h1) rxStateQ <= RX_STOP;
               end
            end
            RX_STOP: if (baudTick) begin
               rxTickQ <= rxTickQ + 4'h1;
               if (rxTickQ == RX_LAST) begin
                  rxStateQ <= rxBreak ? RX_WAIT : RX_IDLE;
               end
            end
            RX_WAIT: if (rxLine) rxStateQ <= RX_IDLE;
            default: rxStateQ <= RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transmitter; stop bits are the ones above the masked data
   ufi_tx_state_t txStateQ;
   logic [11:0]   txShQ, txFrame;
   logic [3:0]    txTickQ, txLeftQ;
   logic [7:0]    txHead;

   assign txHead = txMemQ[txRdPtrQ] & dataMask;
   assign txPop  = txStateQ == TX_IDLE && txCntQ != 5'h00;
   assign txBit  = !lcrQ[LCR_BREAK] && (txStateQ == TX_IDLE || txShQ[0]);

   always_comb begin
      txFrame = {3'b111, txHead | ~dataMask, 1'b0};
      if (pen) begin
         txFrame[dataBits + 4'h1] = lcrQ[LCR_STICK] ? !eps : (^txHead) ^ !eps;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         txStateQ <= TX_IDLE;
         txShQ    <= 12'hFFF;
         txTickQ  <= 4'h0;
         txLeftQ  <= 4'h0;
      end else begin
         unique case (txStateQ)
            TX_IDLE: if (txPop) begin
               txShQ    <= txFrame;
               txLeftQ  <= charBits;
               txTickQ  <= 4'h0;
               txStateQ <= TX_SHIFT;
            end
            TX_SHIFT: if (baudTick) begin
               txTickQ <= txTickQ + 4'h1;
               if (txTickQ == RX_LAST) begin
                  txShQ   <= {1'b1, txShQ[11:1]};
                  txLeftQ <= txLeftQ - 4'h1;
                  if (txLeftQ == 4'h1) txStateQ <= TX_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // holding-empty flag and transmit event
   logic       holdEmptyQ, multiQ, dlyActQ, thrIntQ, thrSet, lastPop;
   logic [7:0] dlyCntQ;

   assign lastPop = txPop && txCntQ == 5'h01 && !txPush;
   // single-byte bursts wait a character less the stop bit
   // a fifo enable change or clear sets it at once
   assign thrSet  = (lastPop && multiQ) || txClear ||
                    (dlyActQ && baudTick && dlyCntQ == 8'h01);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         holdEmptyQ <= 1'b1;
         multiQ     <= 1'b0;
         dlyActQ    <= 1'b0;
         dlyCntQ    <= 8'h00;
      end else begin
         if (thrSet) holdEmptyQ <= 1'b1;
         if (txPush) holdEmptyQ <= 1'b0;
         if (thrSet) multiQ <= 1'b0;
         if (txCntQ >= 5'h02) multiQ <= 1'b1;
         if (lastPop && !multiQ) begin
            dlyActQ <= 1'b1;
            dlyCntQ <= charTicks - BIT_TICKS;
         end else if (thrSet || txPush) begin
            dlyActQ <= 1'b0;
         end else if (dlyActQ && baudTick) begin
            dlyCntQ <= dlyCntQ - 8'h01;
         end
      end
   end

   // write or ident read clears; a same-cycle set wins
   always_ff @(posedge clk) begin
      if (!resetn) begin
         thrIntQ <= 1'b0;
      end else if ((thrSet && ierQ[1]) ||
                   (ierWr && wrData[1] && !ierQ[1] && holdEmptyQ)) begin
         thrIntQ <= 1'b1;
      end else if (txPush || (iirRd && iirId == IID_HOLDING_EMPTY_FLAG)) begin
         thrIntQ <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receive timeout timer, four character times of baud ticks
   logic [9:0] toCntQ, toLimit;
   logic       toFlag;

   assign toLimit = {6'h00, charBits} * TO_TICKS;
   assign toFlag  = rxCntQ != 5'h00 && toCntQ >= toLimit;

   always_ff @(posedge clk) begin
      if (!resetn || rxPush || rxPop || rxCntQ == 5'h00) begin
         toCntQ <= 10'h000;
      end else if (baudTick && toCntQ < toLimit) begin
         toCntQ <= toCntQ + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // line errors: overrun at once, others when the char reaches the head
   logic [3:0]  lsrErrQ, errSet;
   logic [10:0] headEntry;
   logic        headEv, temt;

   assign headEv    = (rxPush && (rxCntQ == 5'h00 ||
                       (rxPop && rxCntQ == 5'h01))) ||
                      (rxPop && rxCntQ > 5'h01);
   assign headEntry = (rxPop && rxCntQ > 5'h01) ?
                      rxMemQ[rxRdPtrQ + 4'h1] : rxEntry;
   assign errSet    = {headEv ? headEntry[10:8] : 3'b000, rxDone && rxFull};
   assign temt      = txCntQ == 5'h00 && txStateQ == TX_IDLE;
   // dr, errors, empty flags and fifo error summary
   assign lsrVal    = {fifoEnQ && rxErrCntQ != 5'h00, temt, holdEmptyQ,
                       lsrErrQ, rxCntQ != 5'h00};

   always_ff @(posedge clk) begin
      if (!resetn) begin
         lsrErrQ <= 4'h0;
      end else begin
         lsrErrQ <= (lsrRd ? 4'h0 : lsrErrQ) | errSet;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // modem status; loopback feeds the control bits back
   logic [3:0] msrCur, msrPrevQ, msrDeltaQ;

   assign msrCur = loopMode ? {mcrQ[3], mcrQ[2], mcrQ[0], mcrQ[1]}
                            : ~pinSyncQ[4:1];

   always_ff @(posedge clk) begin
      if (!resetn) begin
         msrPrevQ  <= 4'h0;
         msrDeltaQ <= 4'h0;
      end else begin
         msrPrevQ  <= msrCur;
         msrDeltaQ <= (msrRd ? 4'h0 : msrDeltaQ) |
                      {msrPrevQ[3] ^ msrCur[3], msrPrevQ[2] & !msrCur[2],
                       msrPrevQ[1] ^ msrCur[1], msrPrevQ[0] ^ msrCur[0]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ident priority; cleared enables leave a side polled
   always_comb begin
      if (ierQ[2] && lsrErrQ != 4'h0) begin
         iirId = IID_LSI;
      end else if (ierQ[0] && (fifoEnQ ? rxCntQ >= trigLevel
                                       : rxCntQ != 5'h00)) begin
         iirId = IID_RDA;
      end else if (ierQ[0] && fifoEnQ && toFlag) begin
         iirId = IID_TO;
      end else if (ierQ[1] && thrIntQ) begin
         iirId = IID_HOLDING_EMPTY_FLAG;
      end else if (ierQ[3] && msrDeltaQ != 4'h0) begin
         iirId = IID_MSI;
      end else begin
         iirId = IID_NONE;
      end
   end

   always_comb begin
      unique case (addr)
         ADDR_DATA: rdMux = dlab ? divQ[7:0] : rxMemQ[rxRdPtrQ][7:0];
         ADDR_IER:  rdMux = dlab ? divQ[15:8] : {4'h0, ierQ};
         ADDR_IIR:  rdMux = {fifoEnQ, fifoEnQ, 2'b00, iirId};
         ADDR_LCR:  rdMux = lcrQ;
         ADDR_MCR:  rdMux = {3'b000, mcrQ};
         ADDR_LSR:  rdMux = lsrVal;
         ADDR_MSR:  rdMux = {msrCur, msrDeltaQ};
         ADDR_SCR:  rdMux = scrQ;
      endcase
   end

   // serial and modem outputs idle high; loopback keeps the pins quiet
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdDataQ <= 8'h00;
         intrQ   <= 1'b0;
         pinOutQ <= PIN_RESET;
      end else begin
         rdDataQ <= rdStb ? rdMux : 8'h00;
         intrQ   <= iirId != IID_NONE;
         pinOutQ <= loopMode ? PIN_RESET : {txBit, ~mcrQ[3:0]};
      end
   end

   assign rdData         = rdDataQ;
   assign intr           = intrQ;
   assign serialOutA     = pinOutQ[4];
   assign userOutputTwoN = pinOutQ[3];
   assign userOutputOneN = pinOutQ[2];
   assign requestSendN   = pinOutQ[1];
   assign terminalReadyN = pinOutQ[0];

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   rda_level_a: assert property (ierQ[0] && fifoEnQ && lsrErrQ == 4'h0 &&
      rxCntQ >= trigLevel |-> iirId == IID_RDA)
      else $error("trigger level not reported");
   lsi_prio_a: assert property (ierQ[2] && lsrErrQ != 4'h0
      |-> iirId == IID_LSI) else $error("line status lost priority");
   dr_set_a: assert property (rxPush && !rxPop && !rxClear |=>
      lsrVal[0]) else $error("data ready missing");
   timeout_a: assert property (iirId == IID_TO |->
      rxCntQ != 5'h00 && toCntQ >= toLimit) else $error("early timeout");
   to_clear_a: assert property (iirId == IID_TO && rxPop && !rxPush
      |=> toCntQ == 10'h000 && iirId != IID_TO) else $error("timeout stuck");
   // a same-cycle set keeps the event, so only a lone write must clear it
   thr_clear_a: assert property (txPush && !thrSet |=>
      !thrIntQ && !holdEmptyQ) else $error("holding write did not clear");
   fcr_imm_a: assert property (enChange && ierQ[1] |=>
      thrIntQ && holdEmptyQ) else $error("no immediate transmit event");
   polled_a: assert property (!ierQ[0] |->
      iirId != IID_RDA && iirId != IID_TO) else $error("polled rx event");
   dly_a: assert property (lastPop && !multiQ |=> !holdEmptyQ [*3])
      else $error("empty indication not delayed");

   to_seen_c: cover property (iirId == IID_TO ##1 rxPop);
   ovr_seen_c: cover property (rxDone && rxFull);
   dly_seen_c: cover property (dlyActQ ##[1:1000] holdEmptyQ && thrIntQ);

endmodule // ufi_uart
`default_nettype wire

// ===== rtl/ufi_pkg.sv
// ufi_pkg: constants and types of the fifo-mode serial port core.
// assumes a single 100 MHz clock and a byte-wide register port.
package ufi_pkg;

   ////////////////////////////////////////////////////////////////////
   // register addresses (three address bits)
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_IER  = 3'h1;
   localparam logic [2:0] ADDR_IIR  = 3'h2;
   localparam logic [2:0] ADDR_LCR  = 3'h3;
   localparam logic [2:0] ADDR_MCR  = 3'h4;
   localparam logic [2:0] ADDR_LSR  = 3'h5;
   localparam logic [2:0] ADDR_MSR  = 3'h6;
   localparam logic [2:0] ADDR_SCR  = 3'h7;

   // field positions
   localparam int LCR_STB   = 2;
   localparam int LCR_PEN   = 3;
   localparam int LCR_EPS   = 4;
   localparam int LCR_STICK = 5;
   localparam int LCR_BREAK = 6;
   localparam int LCR_DLAB  = 7;
   localparam int MCR_LOOP  = 4;

   // identification codes, low nibble of the ident register
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_LSI  = 4'h6;
   localparam logic [3:0] IID_RDA  = 4'h4;
   localparam logic [3:0] IID_TO   = 4'hC;
   localparam logic [3:0] IID_HOLDING_EMPTY_FLAG = 4'h2;
   localparam logic [3:0] IID_MSI  = 4'h0;

   // reset values
   localparam logic [7:0] LSR_RESET = 8'h60;
   localparam logic [4:0] PIN_RESET = 5'h1F;

   // fifo depth and receive trigger levels
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [4:0] TRIG_L0    = 5'h01;
   localparam logic [4:0] TRIG_L1    = 5'h04;
   localparam logic [4:0] TRIG_L2    = 5'h08;
   localparam logic [4:0] TRIG_L3    = 5'h0E;

   // clock prescale to the 16x base rate (normal, double, quadruple)
   localparam logic [7:0] PRE_NORM = 8'h36;
   localparam logic [7:0] PRE_HS2  = 8'h1B;
   localparam logic [7:0] PRE_HS4  = 8'h0E;

   // character timing in 16x ticks
   localparam logic [7:0] BIT_TICKS     = 8'h10;
   localparam logic [3:0] RX_MID        = 4'h7;
   localparam logic [3:0] RX_LAST       = 4'hF;
   localparam logic [9:0] TIMEOUT_CHARS = 10'h004;
   localparam logic [9:0] TO_TICKS      = TIMEOUT_CHARS * 10'h010;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_BITS  = 3'b010,
      RX_STOP  = 3'b011,
      RX_WAIT  = 3'b100
   } ufi_rx_state_t;

   typedef enum logic {
      TX_IDLE  = 1'b0,
      TX_SHIFT = 1'b1
   } ufi_tx_state_t;

endpackage

// ===== testbench/ufi_serial_peer.sv
// ufi_serial_peer: remote end, sends and receives 8N1 characters.
// assumes divisor 1 for sending: one bit is 16 ticks of 54 clk.
`timescale 1ns/1ps
`default_nettype none
module ufi_serial_peer (
   input  wire logic clk,
   input  wire logic rxLine,
   output logic      txLine
);
   localparam int BitClk = 864;
   initial txLine = 1'b1; // line idles at mark
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin // lsb first, one stop
         @(posedge clk) txLine <= f[i];
         repeat (BitClk - 1) @(posedge clk);
      end
   endtask
   // samples mid-bit from the start edge; bitClk is clk per bit
   task automatic recv(input int bitClk, output logic [7:0] b);
      wait (rxLine === 1'b0);
      repeat (bitClk / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bitClk) @(posedge clk);
         b[i] = rxLine;
      end
   endtask
endmodule // ufi_serial_peer
`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: register-port scenarios for ufi_uart with a serial sender.
// assumes divisor 1 and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ufi_pkg::*;
   logic       clk = 1'b0, resetn = 1'b0, wrStb = 1'b0, rdStb = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wrData = 8'h00;
   logic [7:0] rdData;
   logic       serialIn, serialOutA, rtsN, dtrN, o1N, o2N, intr;
   logic       highSpeed = 1'b0, ctsN = 1'b1;
   int         err_count = 0, n_tests = 0, cyc = 0;
   always #5 clk = ~clk;
   ufi_serial_peer u_ufi_serial_peer (.clk(clk), .rxLine(serialOutA),
      .txLine(serialIn));
   ufi_uart u_ufi_uart (.clk(clk), .resetn(resetn), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .highSpeed(highSpeed), .serialIn(serialIn), .ctsN(ctsN), .dsrN(1'b1),
      .riN(1'b1), .dcdN(1'b1), .serialOutA(serialOutA),
      .requestSendN(rtsN), .terminalReadyN(dtrN),
      .userOutputOneN(o1N), .userOutputTwoN(o2N), .intr(intr));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) {addr, wrData, wrStb} <= {a, d, 1'b1};
      @(posedge clk) wrStb <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk) {addr, rdStb} <= {a, 1'b1};
      @(posedge clk) rdStb <= 1'b0;
      #1 chk($sformatf("reg %0d", a), e, rdData);
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(ADDR_IER, 8'h00);
      rd(ADDR_IIR, 8'h01);
      rd(ADDR_LCR, 8'h00);
      rd(ADDR_MCR, 8'h00);
      rd(ADDR_LSR, LSR_RESET);
      rd(ADDR_MSR, 8'h00);
      chk("pins", {3'h0, PIN_RESET}, {3'h0, serialOutA, rtsN, dtrN, o1N, o2N});
      @(posedge clk) ctsN <= 1'b0;
      repeat (4) @(posedge clk);
      rd(ADDR_MSR, 8'h11);
      rd(ADDR_MSR, 8'h10);
      @(posedge clk) ctsN <= 1'b1;
   endtask
   task automatic t_rx();
      wr(ADDR_LCR, 8'h80);
      wr(ADDR_DATA, 8'h01);
      wr(ADDR_IER, 8'h00);
      wr(ADDR_LCR, 8'h03);
      wr(ADDR_IIR, 8'h01);
      wr(ADDR_IER, 8'h01);
      u_ufi_serial_peer.send(8'h5A);
      #1 chk("intr", 8'h01, {7'h00, intr});
      rd(ADDR_IIR, 8'hC4);
      rd(ADDR_LSR, 8'h61);
      rd(ADDR_DATA, 8'h5A);
      rd(ADDR_IIR, 8'hC1);
      chk("intr", 8'h00, {7'h00, intr});
      rd(ADDR_LSR, 8'h60);
   endtask
   // slow by nature: four idle character times are 34560 clk
   task automatic t_timeout();
      wr(ADDR_IIR, 8'h41);
      u_ufi_serial_peer.send(8'h33);
      rd(ADDR_IIR, 8'hC1);
      repeat (36000) @(posedge clk);
      rd(ADDR_IIR, 8'hCC);
      rd(ADDR_DATA, 8'h33);
      rd(ADDR_IIR, 8'hC1);
   endtask
   task automatic t_tx();
      logic [7:0] b;
      wr(ADDR_IER, 8'h02);
      rd(ADDR_IIR, 8'hC2);
      wr(ADDR_DATA, 8'h41);
      rd(ADDR_IIR, 8'hC1);
      rd(ADDR_LSR, 8'h00);
      u_ufi_serial_peer.recv(16 * int'(PRE_NORM), b);
      chk("serial byte", 8'h41, b);
      // past the delayed empty indication and the last stop bit
      repeat (2000) @(posedge clk);
      #1 chk("intr", 8'h01, {7'h00, intr});
      rd(ADDR_LSR, LSR_RESET);
      rd(ADDR_IIR, 8'hC2);
      rd(ADDR_IIR, 8'hC1);
   endtask
   task automatic t_high_speed();
      logic [7:0] b;
      @(posedge clk) highSpeed <= 1'b1;
      wr(ADDR_LCR, 8'h83);
      wr(ADDR_DATA, 8'h02);
      wr(ADDR_IER, 8'h80);
      wr(ADDR_LCR, 8'h03);
      wr(ADDR_DATA, 8'hA5);
      u_ufi_serial_peer.recv(16 * int'(PRE_HS2), b);
      chk("fast byte", 8'hA5, b);
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_rx();
      t_timeout();
      t_tx();
      t_high_speed();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
